// ---- src/acc_conv_ctrl.sv ----
// Conversion control block: registers, trigger, sequencing and threshold error
//
// Function
// - Continuous mode sets the start bit again after each completed conversion.
// - Retrigger stops on threshold flag with stop-on-interrupt, or when start is cleared.
// - Writing one to start together with enable begins a conversion; bit reads one while busy.
// - Justify bit set gives right-justified results, clear gives left, zero-filled.
// - A writable 16-bit threshold setpoint in high and low byte registers.
// - Read-only upper byte of the setpoint error, formed by the calc mode.
// - Selector codes trigger on software reads of result-high or error-high byte.
// - Selector code starts a conversion on interrupt-on-change flag assertion.
// - Selector codes route PWM channel 3 and capture/compare 2 and 1 events.
// - Unimplemented control and selector bits ignore writes and read zero.
// - Control and selector reset to zero; setpoint and error start unknown.
// - Retrigger is decided at the same edge as the accumulator update and persists until reset or stop.
`timescale 1ns/100ps
module acc_conv_ctrl
  import acc_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Converter sample value and trigger sources
  input wire logic [RES_W-1:0] i_sample,
  input wire acc_events_s i_events,
  // Status outputs
  output logic o_busy,
  output logic o_irq
);
  acc_state_e state_r;
  acc_state_e state_nxt;
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl3_r;
  logic [4:0] trig_sel_r;
  logic [15:0] stpt_r;
  logic [15:0] err_r;
  logic [RES_W-1:0] result_r;
  logic [RES_W-1:0] prev_r;
  logic [15:0] acc_r;
  logic [7:0] cnt_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [31:0] hrdata_r;
  acc_events_s ev_s1_r;
  acc_events_s ev_s2_r;
  logic ph_wr_r;
  logic ph_rd_r;
  logic [7:0] ph_addr_r;

  logic addr_phase;
  logic wr_now;
  logic [31:0] rd_mux;
  logic rd_res_hi;
  logic rd_err_hi;
  logic soft_wr;
  logic hw_trigger;
  logic enable;
  logic start_bit;
  logic done;
  logic thresh_hit;
  logic retrig;
  logic start_req;
  logic [15:0] res_word;
  logic [15:0] prev_word;
  logic [15:0] err_calc;
  logic [7:0] ctrl0_wr;
  logic ctrl0_hit;
  logic [IRQ_W-1:0] irq_evt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // Address phase captured only when the previous data phase completes
  assign addr_phase = i_hsel & i_hready & i_htrans[1];
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = hrdata_r;
  assign wr_now = ph_wr_r;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_addr_r <= 8'h00;
    end else begin
      ph_wr_r <= addr_phase & i_hwrite;
      ph_rd_r <= addr_phase & ~i_hwrite;
      ph_addr_r <= i_haddr;
    end
  end

  assign enable = ctrl0_r[CTRL0_ENABLE_BIT];
  assign start_bit = ctrl0_r[CTRL0_START_BIT];

  // Read data registered at the address phase so it stands in the data phase
  always_comb begin
    if (hit(i_haddr, ADDR_CTRL0)) begin
      rd_mux = {24'h0, ctrl0_r};
    end else if (hit(i_haddr, ADDR_STPT_HI)) begin
      rd_mux = {24'h0, stpt_r[15:8]};
    end else if (hit(i_haddr, ADDR_STPT_LO)) begin
      rd_mux = {24'h0, stpt_r[7:0]};
    end else if (hit(i_haddr, ADDR_ERR_HI)) begin
      rd_mux = {24'h0, err_r[15:8]};
    end else if (hit(i_haddr, ADDR_TRIG_SEL)) begin
      rd_mux = {27'h0, trig_sel_r};
    end else if (hit(i_haddr, ADDR_CTRL3)) begin
      rd_mux = {24'h0, ctrl3_r};
    end else if (hit(i_haddr, ADDR_RESULT)) begin
      rd_mux = {16'h0, res_word};
    end else if (hit(i_haddr, ADDR_RES_HI)) begin
      rd_mux = {24'h0, res_word[15:8]};
    end else if (hit(i_haddr, ADDR_PREV)) begin
      rd_mux = {16'h0, prev_word};
    end else if (hit(i_haddr, ADDR_IRQ_STAT)) begin
      rd_mux = {30'h0, irq_stat_r};
    end else if (hit(i_haddr, ADDR_IRQ_MASK)) begin
      rd_mux = {30'h0, irq_mask_r};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  assign rd_res_hi = addr_phase & ~i_hwrite & hit(i_haddr, ADDR_RES_HI);
  assign rd_err_hi = addr_phase & ~i_hwrite & hit(i_haddr, ADDR_ERR_HI);
  assign soft_wr = wr_now & hit(ph_addr_r, ADDR_SOFT_TRIG);
  // A start written in the completion cycle survives the hardware clear
  assign ctrl0_hit = wr_now & hit(ph_addr_r, ADDR_CTRL0);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_phase & ~i_hwrite) begin
      hrdata_r <= rd_mux;
    end
  end

  // Peripheral events come from other logic paths; synchronise them anyway
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ev_s1_r <= '0;
      ev_s2_r <= '0;
    end else begin
      ev_s1_r <= i_events;
      ev_s2_r <= ev_s1_r;
    end
  end

  acc_trig_sel u_trig (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_sel(trig_sel_r),
    .i_events(ev_s2_r),
    .i_rd_res_hi(rd_res_hi),
    .i_rd_err_hi(rd_err_hi),
    .i_soft_wr(soft_wr),
    .o_trigger(hw_trigger)
  );

  acc_justify u_just_res (
    .i_right(ctrl0_r[CTRL0_JUSTIFY_BIT]),
    .i_value(result_r),
    .o_word(res_word)
  );

  acc_justify u_just_prev (
    .i_right(ctrl0_r[CTRL0_JUSTIFY_BIT]),
    .i_value(prev_r),
    .o_word(prev_word)
  );

  // Sequencer
  assign done = (state_r == ACC_FINISH);
  assign err_calc = ctrl3_r[CTRL3_CALC_LSB] ?
    (16'(i_sample) - stpt_r) : (16'(i_sample) - 16'(result_r));
  // Threshold event: error above zero (signed) in the selected mode
  assign thresh_hit = done & ($signed(err_calc) > 0);
  // Stop-on-interrupt blocks the retrigger once the threshold flag is or becomes set
  assign retrig = ctrl0_r[CTRL0_CONT_BIT] & start_bit &
    ~(ctrl3_r[CTRL3_SOI_BIT] & (thresh_hit | irq_stat_r[IRQ_THRESH_BIT]));
  assign start_req = enable & (start_bit | hw_trigger);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ACC_IDLE: begin
        if (start_req) begin
          state_nxt = ACC_CONVERT;
        end
      end
      ACC_CONVERT: begin
        if (!enable) begin
          state_nxt = ACC_IDLE;
        end else if (cnt_r == 8'(CONV_LEN - 1)) begin
          state_nxt = ACC_FINISH;
        end
      end
      ACC_FINISH: begin
        state_nxt = ACC_IDLE;
      end
      default: begin
        state_nxt = ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= ACC_IDLE;
      cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= (state_r == ACC_CONVERT) ? cnt_r + 8'h01 : 8'h00;
    end
  end

  // Start bit: hardware trigger sets, completion clears unless retriggered
  always_comb begin
    ctrl0_wr = ctrl0_r;
    if (ctrl0_hit) begin
      ctrl0_wr = i_hwdata[7:0] & CTRL0_WR_MASK;
      ctrl0_wr[CTRL0_START_BIT] = i_hwdata[CTRL0_START_BIT] & i_hwdata[CTRL0_ENABLE_BIT];
    end
    if (done & ~ctrl0_hit) begin
      ctrl0_wr[CTRL0_START_BIT] = retrig & ctrl0_wr[CTRL0_START_BIT];
    end
    if (enable & hw_trigger) begin
      ctrl0_wr[CTRL0_START_BIT] = 1'b1;
    end
    if (!ctrl0_wr[CTRL0_ENABLE_BIT]) begin
      ctrl0_wr[CTRL0_START_BIT] = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl0_r <= CTRL0_RESET;
      ctrl3_r <= CTRL3_RESET;
      trig_sel_r <= TRIG_RESET;
    end else begin
      ctrl0_r <= ctrl0_wr;
      if (wr_now & hit(ph_addr_r, ADDR_CTRL3)) begin
        ctrl3_r <= i_hwdata[7:0] & CTRL3_WR_MASK;
      end
      if (wr_now & hit(ph_addr_r, ADDR_TRIG_SEL)) begin
        trig_sel_r <= i_hwdata[4:0];
      end
    end
  end

  // Setpoint and error have no reset: they start unknown
  always_ff @(posedge i_ref_clk) begin
    if (wr_now & hit(ph_addr_r, ADDR_STPT_HI)) begin
      stpt_r[15:8] <= i_hwdata[7:0];
    end
    if (wr_now & hit(ph_addr_r, ADDR_STPT_LO)) begin
      stpt_r[7:0] <= i_hwdata[7:0];
    end
    if (done) begin
      err_r <= err_calc;
    end
  end

  // Accumulator updated in the same edge that decides the retrigger
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      result_r <= '0;
      prev_r <= '0;
      acc_r <= 16'h0000;
    end else if (done) begin
      prev_r <= result_r;
      result_r <= i_sample;
      acc_r <= acc_r + 16'(i_sample);
    end
  end

  // Interrupts: set wins over write-one-to-clear
  assign irq_evt = {thresh_hit, done};
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      if (wr_now & hit(ph_addr_r, ADDR_IRQ_STAT)) begin
        irq_stat_r <= (irq_stat_r & ~i_hwdata[IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
      if (wr_now & hit(ph_addr_r, ADDR_IRQ_MASK)) begin
        irq_mask_r <= i_hwdata[IRQ_W-1:0];
      end
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);
  assign o_busy = start_bit;
endmodule

// ---- src/acc_justify.sv ----
// Result justification of a 10-bit value into a 16-bit word
`timescale 1ns/100ps
module acc_justify
  import acc_pkg::*;
(
  // Control
  input wire logic i_right,
  // Data
  input wire logic [RES_W-1:0] i_value,
  output logic [15:0] o_word
);
  // Left form fills the low bits with zeros
  assign o_word = i_right ? {{(16-RES_W){1'b0}}, i_value} : {i_value, {(16-RES_W){1'b0}}};
endmodule

// ---- src/acc_pkg.sv ----
// Package: register map, field layout and enumerations of the conversion control block
package acc_pkg;
  // Register byte addresses (one aligned word each)
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_STPT_HI = 8'h04;
  localparam logic [7:0] ADDR_STPT_LO = 8'h08;
  localparam logic [7:0] ADDR_ERR_HI = 8'h0C;
  localparam logic [7:0] ADDR_TRIG_SEL = 8'h10;
  localparam logic [7:0] ADDR_CTRL3 = 8'h14;
  localparam logic [7:0] ADDR_RESULT = 8'h18;
  localparam logic [7:0] ADDR_RES_HI = 8'h1C;
  localparam logic [7:0] ADDR_PREV = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
  localparam logic [7:0] ADDR_SOFT_TRIG = 8'h2C;
  // Control register 0 fields
  localparam int CTRL0_ENABLE_BIT = 7;
  localparam int CTRL0_CONT_BIT = 6;
  localparam int CTRL0_CLKSEL_BIT = 4;
  localparam int CTRL0_JUSTIFY_BIT = 2;
  localparam int CTRL0_START_BIT = 0;
  localparam logic [7:0] CTRL0_WR_MASK = 8'hD5;
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  // Control register 3 fields
  localparam int CTRL3_SOI_BIT = 3;
  localparam int CTRL3_CALC_LSB = 0;
  localparam logic [7:0] CTRL3_WR_MASK = 8'h0F;
  localparam logic [7:0] CTRL3_RESET = 8'h00;
  localparam logic [4:0] TRIG_RESET = 5'h00;
  // Interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_THRESH_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int RES_W = 10;
  localparam int CONV_CYCLES = 12;
  // Trigger selector codes
  localparam logic [4:0] TRG_SOFT_WRITE = 5'h1F;
  localparam logic [4:0] TRG_READ_RESH = 5'h1D;
  localparam logic [4:0] TRG_READ_ERRH = 5'h1C;
  localparam logic [4:0] TRG_IOC_FLAG = 5'h0F;
  localparam logic [4:0] TRG_PWM3 = 5'h0B;
  localparam logic [4:0] TRG_CCP2 = 5'h0A;
  localparam logic [4:0] TRG_CCP1 = 5'h09;
  typedef enum logic [1:0] {ACC_IDLE, ACC_CONVERT, ACC_FINISH} acc_state_e;
  typedef struct packed {
    logic ioc_flag;
    logic pwm_channel3_output;
    logic capture_compare2_event;
    logic capture_compare1_event;
  } acc_events_s;
endpackage

// ---- src/acc_trig_sel.sv ----
// Auto-conversion trigger selector with rising-edge detection of peripheral events
`timescale 1ns/100ps
module acc_trig_sel
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Selection and sources
  input wire logic [4:0] i_sel,
  input wire acc_events_s i_events,
  input wire logic i_rd_res_hi,
  input wire logic i_rd_err_hi,
  input wire logic i_soft_wr,
  // Trigger pulse
  output logic o_trigger
);
  acc_events_s prev_r;
  logic ev_edge;
  logic rd_trig;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prev_r <= '0;
    end else begin
      prev_r <= i_events;
    end
  end

  // Level events count once per assertion, not per held cycle
  assign ev_edge = (i_sel == TRG_IOC_FLAG) ? (i_events.ioc_flag & ~prev_r.ioc_flag) :
    (i_sel == TRG_PWM3) ? (i_events.pwm_channel3_output & ~prev_r.pwm_channel3_output) :
    (i_sel == TRG_CCP2) ? (i_events.capture_compare2_event & ~prev_r.capture_compare2_event) :
    (i_sel == TRG_CCP1) ? (i_events.capture_compare1_event & ~prev_r.capture_compare1_event) :
    1'b0;
  assign rd_trig = ((i_sel == TRG_READ_RESH) & i_rd_res_hi) |
    ((i_sel == TRG_READ_ERRH) & i_rd_err_hi) |
    ((i_sel == TRG_SOFT_WRITE) & i_soft_wr);
  // Reserved codes fall through to no trigger
  assign o_trigger = ev_edge | rd_trig;
endmodule

// ---- verif/acc_conv_ctrl_properties.sv ----
// Checker of bus, start and interrupt behaviour of the conversion control block
`timescale 1ns/100ps
module acc_conv_ctrl_props
  import acc_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Bus
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  // Status
  input wire logic o_busy,
  input wire logic o_irq
);
  logic dp_r;
  logic dwr_r;
  logic [7:0] dadr_r;
  logic [7:0] cnt_r;
  wire ap = i_hsel & i_hready & i_htrans[1];
  wire rd_ap = ap & ~i_hwrite;
  wire wr_dp = dp_r & dwr_r;
  wire ctl_wr = wr_dp & (dadr_r == ADDR_CTRL0);
  // Busy run length, so an early clear shows up
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dp_r <= 1'b0;
      dwr_r <= 1'b0;
      dadr_r <= 8'h00;
      cnt_r <= 8'h00;
    end else begin
      dp_r <= ap;
      dwr_r <= i_hwrite;
      dadr_r <= i_haddr;
      cnt_r <= o_busy ? cnt_r + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_start_req;
    ctl_wr && i_hwdata[7] && i_hwdata[0];
  endsequence
  sequence s_run3;
    $rose(o_busy) ##1 !ctl_wr [*2];
  endsequence
  AST_HREADY: assert property (o_hreadyout) else $error("hreadyout low");
  AST_OKAY: assert property (!o_hresp) else $error("error response");
  AST_START: assert property (s_start_req |=> o_busy) else $error("start lost");
  AST_GATED: assert property (ctl_wr && !i_hwdata[7] |=> !o_busy)
    else $error("busy while disabled");
  AST_HOLD: assert property (s_run3 |-> o_busy) else $error("busy dropped early");
  AST_MIN_RUN: assert property ($fell(o_busy) && !$past(ctl_wr) |-> cnt_r >= 8'(CONV_LEN + 1))
    else $error("conversion too short");
  AST_RDATA: assert property (!$past(rd_ap) |-> $stable(o_hrdata)) else $error("rdata moved");
  AST_UNMAP: assert property (dp_r && !dwr_r && dadr_r > ADDR_SOFT_TRIG |-> o_hrdata == 32'h0)
    else $error("unmapped read nonzero");
  AST_MASK: assert property (wr_dp && dadr_r == ADDR_IRQ_MASK && i_hwdata[1:0] == 2'b00
    |=> !o_irq) else $error("masked irq high");
  AST_IRQ_CLR: assert property (wr_dp && dadr_r == ADDR_IRQ_STAT && i_hwdata[1:0] == 2'b11
    && !o_busy |=> !o_irq) else $error("irq not cleared");
endmodule

bind acc_conv_ctrl acc_conv_ctrl_props #(.CONV_LEN(CONV_LEN)) u_props (
  .i_ref_clk, .i_sys_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata,
  .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .o_busy, .o_irq
);

// ---- verif/tb_adc_conversion_control.sv ----
// Self-checking bench of the conversion control block over AHB-Lite
`timescale 1ns/100ps
module tb_adc_conversion_control
  import acc_pkg::*;
;
  localparam int CL = 4;
  logic ref_clk;
  logic sys_rst;
  logic hsel;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [RES_W-1:0] sample;
  acc_events_s ev;
  logic busy;
  logic irq;
  logic [31:0] q;
  logic [4:0] codes [7];
  int failures;
  int checks;

  acc_conv_ctrl #(.CONV_LEN(CL)) dut_u (
    .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .i_sample(sample), .i_events(ev), .o_busy(busy), .o_irq(irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  // Every wait is bounded; a hang ends the run as a mismatch
  task automatic wait_on(input logic v, input bit on_busy);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 50) begin
        chk("wait", v, on_busy ? busy : hreadyout);
        wrap_up();
      end
    end while ((on_busy ? busy : hreadyout) !== v);
    checks++;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_on(1'b1, 1'b0);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_on(1'b1, 1'b0);
    q = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  // Samples after the edge so the launching edge's update has landed
  task automatic see(input string nm, input logic e, input bit of_irq);
    @(posedge ref_clk);
    chk(nm, e, of_irq ? irq : busy);
  endtask

  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    sample = 10'h2B5;
    ev = '0;
    failures = 0;
    checks = 0;
    codes = '{TRG_SOFT_WRITE, TRG_READ_RESH, TRG_READ_ERRH, TRG_IOC_FLAG, TRG_PWM3,
              TRG_CCP2, TRG_CCP1};
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd(ADDR_CTRL0, 32'h0, "ctrl0 reset");
    rd(ADDR_TRIG_SEL, 32'h0, "trig reset");
    bus(1'b1, ADDR_CTRL0, 32'h2A);
    rd(ADDR_CTRL0, 32'h0, "ctrl0 gaps");
    bus(1'b1, ADDR_TRIG_SEL, 32'hFF);
    rd(ADDR_TRIG_SEL, 32'h1F, "trig gaps");
    rd(8'h30, 32'h0, "unmapped");
    bus(1'b1, ADDR_CTRL0, 32'h01);
    see("start gated", 1'b0, 1'b0);
    $display("reset and access test done");
    bus(1'b1, ADDR_STPT_HI, 32'h7F);
    bus(1'b1, ADDR_STPT_LO, 32'hFF);
    rd(ADDR_STPT_HI, 32'h7F, "setpoint high");
    rd(ADDR_STPT_LO, 32'hFF, "setpoint low");
    bus(1'b1, ADDR_CTRL3, 32'h1);
    bus(1'b1, ADDR_CTRL0, 32'h85);
    rd(ADDR_CTRL0, 32'h85, "start busy");
    wait_on(1'b0, 1'b1);
    rd(ADDR_CTRL0, 32'h84, "start cleared");
    rd(ADDR_RESULT, 32'h2B5, "right result");
    rd(ADDR_ERR_HI, 32'h82, "error high");
    bus(1'b1, ADDR_CTRL0, 32'h81);
    wait_on(1'b0, 1'b1);
    rd(ADDR_RESULT, 32'hAD40, "left result");
    rd(ADDR_PREV, 32'hAD40, "left previous");
    bus(1'b1, ADDR_IRQ_MASK, 32'h0);
    see("irq masked", 1'b0, 1'b1);
    rd(ADDR_IRQ_STAT, 32'h1, "done flag");
    bus(1'b1, ADDR_IRQ_MASK, 32'h1);
    see("irq raised", 1'b1, 1'b1);
    bus(1'b1, ADDR_IRQ_STAT, 32'h3);
    see("irq cleared", 1'b0, 1'b1);
    $display("conversion and interrupt test done");
    bus(1'b1, ADDR_CTRL0, 32'h80);
    for (int k = 0; k < 7; k++) begin
      bus(1'b1, ADDR_TRIG_SEL, {27'h0, codes[k]});
      if (k == 0)
        bus(1'b1, ADDR_SOFT_TRIG, 32'h1);
      else if (k < 3)
        bus(1'b0, (k == 1) ? ADDR_RES_HI : ADDR_ERR_HI, 32'h0);
      else
        ev <= acc_events_s'(4'(1 << (6 - k)));
      wait_on(1'b1, 1'b1);
      ev <= '0;
      wait_on(1'b0, 1'b1);
    end
    ev <= acc_events_s'(4'b0100);
    repeat (8) @(posedge ref_clk);
    chk("other source", 1'b0, busy);
    ev <= '0;
    $display("trigger test done");
    bus(1'b1, ADDR_TRIG_SEL, {27'h0, TRG_SOFT_WRITE});
    bus(1'b1, ADDR_IRQ_STAT, 32'h3);
    bus(1'b1, ADDR_CTRL0, 32'hC1);
    repeat (3 * CL + 9) @(posedge ref_clk);
    rd(ADDR_CTRL0, 32'hC1, "retrigger");
    rd(ADDR_IRQ_STAT, 32'h1, "retrigger done");
    bus(1'b1, ADDR_CTRL0, 32'hC0);
    wait_on(1'b0, 1'b1);
    bus(1'b1, ADDR_STPT_HI, 32'h0);
    bus(1'b1, ADDR_STPT_LO, 32'h0);
    bus(1'b1, ADDR_CTRL3, 32'h9);
    bus(1'b1, ADDR_IRQ_STAT, 32'h3);
    bus(1'b1, ADDR_CTRL0, 32'hC1);
    wait_on(1'b0, 1'b1);
    rd(ADDR_IRQ_STAT, 32'h3, "threshold stop");
    bus(1'b1, ADDR_CTRL0, 32'h81);
    bus(1'b1, ADDR_CTRL0, 32'h01);
    see("abort", 1'b0, 1'b0);
    $display("continuous test done");
    wrap_up();
  end
endmodule
